// ### fpx_allow.sv
// allowed-condition table for each double-precision operation
`timescale 1ns/1ps
`default_nettype none
module fpx_allow (
  input  wire fpx_pkg::fp_op_e op_i,
  output logic [5:0]           allow_o,
  output logic                 sets_flags_o
);
  // purely combinational lookup; kept apart so the table is reviewed on its own
  always_comb begin
    sets_flags_o = 1'b0;
    case (op_i)
      fpx_pkg::add_packed_double, fpx_pkg::add_scalar_double:
        allow_o = fpx_pkg::SET_ARITH;                        // [RQ1]
      fpx_pkg::mul_packed_double, fpx_pkg::mul_scalar_double,
      fpx_pkg::sub_packed_double, fpx_pkg::sub_scalar_double:
        allow_o = fpx_pkg::SET_ARITH;                        // [RQ2]
      fpx_pkg::div_packed_double, fpx_pkg::div_scalar_double:
        allow_o = fpx_pkg::SET_ALL;                          // [RQ3]
      fpx_pkg::cmp_predicate_packed, fpx_pkg::cmp_predicate_scalar:
        allow_o = fpx_pkg::SET_ID;                           // [RQ4]
      fpx_pkg::ordered_cmp_set_flags, fpx_pkg::unordered_cmp_set_flags: begin
        allow_o      = fpx_pkg::SET_ID;                      // [RQ5]
        sets_flags_o = 1'b1;
      end
      fpx_pkg::max_packed_double, fpx_pkg::max_scalar_double,
      fpx_pkg::min_packed_double, fpx_pkg::min_scalar_double:
        allow_o = fpx_pkg::SET_ID;                           // [RQ6]
      fpx_pkg::root_packed_double, fpx_pkg::root_scalar_double:
        allow_o = fpx_pkg::SET_IDP;                          // [RQ7]
      fpx_pkg::int32x4_to_single:
        allow_o = fpx_pkg::SET_P;                            // [RQ10]
      fpx_pkg::single_to_int32x4_round, fpx_pkg::single_to_int32x4_trunc:
        allow_o = fpx_pkg::SET_IP;                           // [RQ11]
      fpx_pkg::double_to_int32_round, fpx_pkg::double_to_int32_trunc,
      fpx_pkg::double_to_legacy_int32_round, fpx_pkg::double_to_legacy_int32_trunc,
      fpx_pkg::scalar_double_to_gpr_round, fpx_pkg::scalar_double_to_gpr_trunc:
        allow_o = fpx_pkg::SET_IP;                           // [RQ12]
      fpx_pkg::narrow_double_to_single, fpx_pkg::narrow_scalar_to_single:
        allow_o = fpx_pkg::SET_ARITH;                        // [RQ14]
      fpx_pkg::widen_single_to_double, fpx_pkg::widen_scalar_to_double:
        allow_o = fpx_pkg::SET_ID;                           // [RQ15]
      fpx_pkg::int32_to_double_packed, fpx_pkg::legacy_int32_to_double,
      fpx_pkg::gpr_int32_to_double:
        allow_o = fpx_pkg::SET_NONE;                         // [RQ13]
      fpx_pkg::bitwise_and_128, fpx_pkg::bitwise_andnot_128,
      fpx_pkg::bitwise_or_128, fpx_pkg::bitwise_xor_128:
        allow_o = fpx_pkg::SET_NONE;                         // [RQ8]
      default:
        allow_o = fpx_pkg::SET_NONE;                         // [RQ9] moves, shuffles
    endcase
  end
endmodule
`default_nettype wire

// ### fpx_flags.sv
// double-precision vector exception gating, sticky status and fault decision
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RQ1) add: all but divide-by-zero
// (RQ2) multiply and subtract: all but divide-by-zero
// (RQ3) divide may flag all six conditions
// (RQ4) predicate compares: invalid and denormal only
// (RQ5) flag-setting compares: integer flags, invalid/denormal
// (RQ6) min/max: invalid and denormal only
// (RQ7) square root: invalid, denormal, precision
// (RQ8) 128-bit bitwise ops flag nothing
// (RQ9) moves, shuffles, sign extract flag nothing
// (RQ10) int32 to single: precision only
// (RQ11) single to int32: invalid, precision; round/truncate
// (RQ12) double to int32: invalid and precision
// (RQ13) int32 to double flags nothing
// (RQ14) narrowing: all but divide-by-zero
// (RQ15) widening: invalid and denormal only
// (RQ16) merge lanes sticky; fault when unmasked
module fpx_flags (
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire fpx_pkg::fp_issue_s issue_i,
  input  wire logic               csr_wr_i,
  input  wire logic [15:0]        csr_wdata_i,
  output logic [15:0]             csr_o,
  output logic [1:0]              round_mode_o,
  output logic                    trunc_o,
  output fpx_pkg::fp_result_s     result_o
);
  // ==========================================================
  // table lookup and lane merge
  logic [5:0] allow;
  logic       sets_flags;
  logic [5:0] lane_merge;
  logic [5:0] cond;
  logic [5:0] mask_bits;
  logic [5:0] next_flags;
  logic [15:0] next_csr;
  logic       is_trunc;
  logic       fault;

  // flags and masks share one six-bit layout, so one helper picks either field
  function automatic logic [5:0] csr_field(input logic [15:0] w_in, input int unsigned lo);
    return w_in[lo +: fpx_pkg::EX_W];
  endfunction

  fpx_allow u_allow (
    .op_i         (issue_i.op),
    .allow_o      (allow),
    .sets_flags_o (sets_flags)
  );

  // or the lanes together, then drop anything the operation cannot raise
  assign lane_merge = (issue_i.lane_en[0] ? issue_i.lane0_cond : 6'h00)
                    | (issue_i.lane_en[1] ? issue_i.lane1_cond : 6'h00);    // [RQ16]
  assign cond       = issue_i.valid ? (lane_merge & allow) : 6'h00;        // [RQ1] [RQ3]
  assign mask_bits  = csr_field(csr_o, fpx_pkg::CSR_MASK_LO);
  assign fault      = |(cond & ~mask_bits);                                 // [RQ16]
  assign is_trunc   = (issue_i.op == fpx_pkg::single_to_int32x4_trunc)
                    | (issue_i.op == fpx_pkg::double_to_int32_trunc)
                    | (issue_i.op == fpx_pkg::double_to_legacy_int32_trunc)
                    | (issue_i.op == fpx_pkg::scalar_double_to_gpr_trunc); // [RQ11]

  // a software write and a new event in one cycle: the event's flags survive
  assign next_flags = csr_field(csr_wr_i ? csr_wdata_i : csr_o, fpx_pkg::CSR_FLAG_LO)
                    | cond;
  always_comb begin
    next_csr = csr_wr_i ? csr_wdata_i : csr_o;
    next_csr[fpx_pkg::CSR_FLAG_LO +: fpx_pkg::EX_W] = next_flags;           // [RQ16]
  end

  // ==========================================================
  // registers
  // control/status register; rounding mode is decoded from its next value
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      csr_o <= fpx_pkg::CSR_RESET;
    end else begin
      csr_o <= next_csr;
    end
  end

  // result and rounding controls registered for the pipeline
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_o     <= '0;
      round_mode_o <= 2'h0;
      trunc_o      <= 1'b0;
    end else begin
      result_o.valid         <= issue_i.valid;
      result_o.cond          <= cond;
      result_o.fault         <= fault;
      result_o.set_int_flags <= issue_i.valid & sets_flags;                 // [RQ5]
      result_o.int_flags     <= (issue_i.valid & sets_flags) ? issue_i.cmp_flags : 3'h0;
      round_mode_o           <= next_csr[fpx_pkg::CSR_RC_LO +: 2];
      trunc_o                <= issue_i.valid & is_trunc;                   // [RQ11]
    end
  end

  // ==========================================================
  // checks
  chk_no_zdiv_add: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ1]
    (issue_i.valid && issue_i.op inside {fpx_pkg::add_packed_double,
     fpx_pkg::add_scalar_double})
      |=> !result_o.cond[fpx_pkg::EX_ZDIV]) else $error("add raised divide-by-zero");
  chk_mul_sub_set: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ2]
    (issue_i.valid && issue_i.op inside {fpx_pkg::mul_packed_double,
     fpx_pkg::mul_scalar_double, fpx_pkg::sub_packed_double, fpx_pkg::sub_scalar_double})
      |=> (result_o.cond & ~fpx_pkg::SET_ARITH) == 6'h00)
    else $error("mul/sub raised a forbidden condition");
  chk_div_pass: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ3]
    (issue_i.valid && issue_i.op == fpx_pkg::div_scalar_double && issue_i.lane_en[0])
      |=> result_o.cond == ($past(issue_i.lane0_cond) | ($past(issue_i.lane_en[1]) ?
          $past(issue_i.lane1_cond) : 6'h00))) else $error("divide lost a condition");
  chk_cmp_only_id: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ4]
    (issue_i.valid && issue_i.op inside {fpx_pkg::cmp_predicate_packed,
     fpx_pkg::cmp_predicate_scalar})
      |=> (result_o.cond & ~fpx_pkg::SET_ID) == 6'h00) else $error("compare bad set");
  chk_cmp_int_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ5]
    (issue_i.valid && issue_i.op == fpx_pkg::unordered_cmp_set_flags)
      |=> result_o.set_int_flags && result_o.int_flags == $past(issue_i.cmp_flags))
    else $error("compare did not set integer flags");
  chk_root_set: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ7]
    (issue_i.valid && issue_i.op inside {fpx_pkg::root_packed_double,
     fpx_pkg::root_scalar_double})
      |=> (result_o.cond & ~fpx_pkg::SET_IDP) == 6'h00) else $error("root bad set");
  chk_bitwise_none: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ8]
    (issue_i.valid && issue_i.op == fpx_pkg::bitwise_xor_128)
      |=> result_o.cond == 6'h00 && !result_o.fault) else $error("bitwise flagged");
  chk_trunc_mark: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ11]
    (issue_i.valid && issue_i.op == fpx_pkg::single_to_int32x4_trunc)
      |=> trunc_o && (result_o.cond & ~fpx_pkg::SET_IP) == 6'h00)
    else $error("truncating convert wrong");
  chk_sticky_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    (!csr_wr_i && csr_o[fpx_pkg::EX_INV]) |=> csr_o[fpx_pkg::EX_INV])
    else $error("sticky flag dropped");
  // divide lets every condition through, so an enabled lane with an unmasked one must fault
  chk_unmasked_fault: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    (issue_i.valid && issue_i.op == fpx_pkg::div_packed_double && issue_i.lane_en[0]
     && |(issue_i.lane0_cond & ~csr_o[fpx_pkg::CSR_MASK_LO +: fpx_pkg::EX_W]))
      |=> result_o.fault)
    else $error("unmasked condition without fault");
  chk_masked_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    (&csr_o[fpx_pkg::CSR_MASK_LO +: fpx_pkg::EX_W])
      |=> !result_o.fault)
    else $error("fault raised while every condition was masked");
  chk_minmax_only_id: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ6]
    (issue_i.valid && issue_i.op inside {fpx_pkg::max_packed_double,
     fpx_pkg::max_scalar_double, fpx_pkg::min_packed_double, fpx_pkg::min_scalar_double})
      |=> (result_o.cond & ~fpx_pkg::SET_ID) == 6'h00)
    else $error("min/max raised a forbidden condition");
  // data movement never touches the value, so nothing may be flagged
  chk_moves_silent: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ9]
    (issue_i.valid && issue_i.op inside {fpx_pkg::move_aligned_double,
     fpx_pkg::move_unaligned_double, fpx_pkg::move_high_double, fpx_pkg::move_low_double,
     fpx_pkg::move_scalar_double, fpx_pkg::extract_sign_bits, fpx_pkg::shuffle_double,
     fpx_pkg::interleave_high_double, fpx_pkg::interleave_low_double})
      |=> result_o.cond == 6'h00 && !result_o.fault)
    else $error("move or shuffle flagged a condition");
  // conversions: each family has its own narrow allowed set
  chk_int_to_single: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ10]
    (issue_i.valid && issue_i.op == fpx_pkg::int32x4_to_single)
      |=> (result_o.cond & ~fpx_pkg::SET_P) == 6'h00)
    else $error("integer to single raised more than precision");
  chk_round_no_trunc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ11]
    (issue_i.valid && issue_i.op == fpx_pkg::single_to_int32x4_round)
      |=> !trunc_o && (result_o.cond & ~fpx_pkg::SET_IP) == 6'h00)
    else $error("rounding convert marked as truncating");
  chk_ctrl_load: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ11] [RQ16]
    csr_wr_i |=> ((csr_o ^ $past(csr_wdata_i)) >> fpx_pkg::CSR_MASK_LO) == 16'h0000
      && round_mode_o == csr_o[fpx_pkg::CSR_RC_LO +: 2])
    else $error("control write did not load masks or rounding mode");
  chk_dbl_to_int: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ12]
    (issue_i.valid && issue_i.op inside {fpx_pkg::double_to_int32_round,
     fpx_pkg::double_to_int32_trunc, fpx_pkg::double_to_legacy_int32_round,
     fpx_pkg::double_to_legacy_int32_trunc, fpx_pkg::scalar_double_to_gpr_round,
     fpx_pkg::scalar_double_to_gpr_trunc})
      |=> (result_o.cond & ~fpx_pkg::SET_IP) == 6'h00)
    else $error("double to integer raised a forbidden condition");
  chk_int_to_double: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ13]
    (issue_i.valid && issue_i.op inside {fpx_pkg::int32_to_double_packed,
     fpx_pkg::legacy_int32_to_double, fpx_pkg::gpr_int32_to_double})
      |=> result_o.cond == 6'h00 && !result_o.fault)
    else $error("integer to double flagged a condition");
  chk_narrow_no_zdiv: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ14]
    (issue_i.valid && issue_i.op inside {fpx_pkg::narrow_double_to_single,
     fpx_pkg::narrow_scalar_to_single})
      |=> (result_o.cond & ~fpx_pkg::SET_ARITH) == 6'h00)
    else $error("narrowing raised divide-by-zero");
  chk_widen_only_id: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ15]
    (issue_i.valid && issue_i.op inside {fpx_pkg::widen_single_to_double,
     fpx_pkg::widen_scalar_to_double})
      |=> (result_o.cond & ~fpx_pkg::SET_ID) == 6'h00)
    else $error("widening raised a forbidden condition");
  chk_no_int_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ5]
    (issue_i.valid && !(issue_i.op inside {fpx_pkg::ordered_cmp_set_flags,
     fpx_pkg::unordered_cmp_set_flags}))
      |=> !result_o.set_int_flags && result_o.int_flags == 3'h0)
    else $error("integer flags set by a non-compare");
  // lane merge and result timing
  chk_lane_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    (issue_i.valid && issue_i.op == fpx_pkg::div_packed_double && !issue_i.lane_en[1])
      |=> result_o.cond == ($past(issue_i.lane_en[0]) ? $past(issue_i.lane0_cond) : 6'h00))
    else $error("disabled lane reached the result");
  chk_valid_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    issue_i.valid |=> result_o.valid)
    else $error("issued instruction produced no result");
  chk_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    !issue_i.valid |=> !result_o.valid && result_o.cond == 6'h00 && !trunc_o)
    else $error("result shown without an issue");
  chk_sticky_set: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ16]
    (issue_i.valid && issue_i.op == fpx_pkg::div_scalar_double && issue_i.lane_en[0]
     && issue_i.lane0_cond[fpx_pkg::EX_ZDIV])
      |=> csr_o[fpx_pkg::CSR_FLAG_LO + fpx_pkg::EX_ZDIV])
    else $error("divide-by-zero flag not recorded");

  cov_div_zero:   cover property (@(posedge sys_clk_i) disable iff (reset_i)
    result_o.valid && result_o.cond[fpx_pkg::EX_ZDIV]);
  cov_fault:      cover property (@(posedge sys_clk_i) disable iff (reset_i) result_o.fault);
  cov_cmp_flags:  cover property (@(posedge sys_clk_i) disable iff (reset_i)
    result_o.set_int_flags);
  cov_wr_and_set: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    csr_wr_i && |cond);
  cov_trunc_seen: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    result_o.valid && trunc_o);
endmodule
`default_nettype wire

// ### fpx_flags_bench.sv
// self-checking bench for the exception gating block against a table model
`timescale 1ns/1ps
`default_nettype none
module fpx_flags_bench;
  logic                sys_clk_i;
  logic                reset_i;
  fpx_pkg::fp_issue_s  issue_i;
  logic                csr_wr_i;
  logic [15:0]         csr_wdata_i;
  logic [15:0]         csr_o;
  logic [1:0]          round_mode_o;
  logic                trunc_o;
  fpx_pkg::fp_result_s result_o;
  int                  err_count;
  int                  comparisons;
  logic [15:0]         lfsr;
  logic [15:0]         m_csr;
  fpx_pkg::fp_result_s p_res;
  logic                p_trunc;
  fpx_pkg::fp_result_s exp_q[$];
  fpx_pkg::fp_issue_s  iss;

  fpx_flags dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .issue_i(issue_i),
    .csr_wr_i(csr_wr_i), .csr_wdata_i(csr_wdata_i), .csr_o(csr_o),
    .round_mode_o(round_mode_o), .trunc_o(trunc_o), .result_o(result_o));

  // ==========================================================
  // model helpers
  // indices follow the opcode list order: arith, div, compares, min/max, root, moves, converts
  function automatic logic [5:0] allow_of(input fpx_pkg::fp_op_e op);
    case (int'(op)) inside
      [0:5], [43:44]:   allow_of = 6'h3b;
      [6:7]:            allow_of = 6'h3f;
      [8:15], [45:46]:  allow_of = 6'h03;
      [16:17]:          allow_of = 6'h23;
      31:               allow_of = 6'h20;
      [32:39]:          allow_of = 6'h21;
      default:          allow_of = 6'h00;
    endcase
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // one clock of stimulus; the previous issue is checked once its edge has landed
  task automatic cycle(input fpx_pkg::fp_issue_s s, input logic wr, input logic [15:0] wd);
    logic [5:0] c;
    @(posedge sys_clk_i);
    issue_i <= s;
    csr_wr_i <= wr;
    csr_wdata_i <= wd;
    #1;
    if (exp_q.size() > 0) begin
      p_res = exp_q.pop_front();
      check(result_o.valid === p_res.valid, "result valid");
      if (p_res.valid) check(result_o === p_res, "result fields");
      check(trunc_o === p_trunc, "truncate flag");
      check({csr_o[14:7], csr_o[5:0]} === {m_csr[14:7], m_csr[5:0]}, "status");
      check(round_mode_o === m_csr[14:13], "round mode");
    end
    c = (s.lane_en[0] ? s.lane0_cond : 6'h00) | (s.lane_en[1] ? s.lane1_cond : 6'h00);
    c = s.valid ? (c & allow_of(s.op)) : 6'h00;
    p_res = '0;
    p_res.valid = s.valid;
    p_res.cond = c;
    p_res.fault = |(c & ~m_csr[12:7]); // mask as held before the edge
    p_res.set_int_flags = s.valid && (int'(s.op) inside {10, 11});
    p_res.int_flags = p_res.set_int_flags ? s.cmp_flags : 3'h0;
    p_trunc = s.valid && (int'(s.op) inside {33, 35, 37, 39});
    if (wr) m_csr = wd;
    m_csr[5:0] = m_csr[5:0] | c; // set wins over a same-cycle clear
    exp_q.push_back(p_res);
  endtask

  task automatic do_reset();
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    issue_i <= '0;
    csr_wr_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    check(csr_o === 16'h1f80 && result_o === '0, "reset state");
    check(trunc_o === 1'b0 && round_mode_o === 2'h0, "reset outputs");
    reset_i <= 1'b0;
    exp_q.delete();
    m_csr = 16'h1f80;
  endtask

  // random issue; bits 6 and 15 of written status data kept zero as they are unused
  task automatic rand_run(input int n, input logic wr_en);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      r[15:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      r[31:16] = lfsr;
      iss = '0;
      iss.valid = r[0] | r[1];
      iss.op = fpx_pkg::fp_op_e'(r[15:2] % 47);
      iss.lane_en = r[17:16];
      iss.lane0_cond = r[23:18];
      iss.lane1_cond = r[29:24];
      iss.cmp_flags = {r[30], r[3], r[31]};
      cycle(iss, wr_en && r[22:19] == 4'h0, {1'b0, r[31:24], 1'b0, r[5:0]});
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // watchdog, about nineteen times the expected run length
  initial begin
    #60000;
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    reset_i = 1'b1;
    issue_i = '0;
    csr_wr_i = 1'b0;
    csr_wdata_i = 16'h0000;
    err_count = 0;
    comparisons = 0;
    lfsr = 16'h0056;
    exp_q.delete();
    m_csr = 16'h1f80;
    do_reset();
    $display("test reset done");
    // every op with all conditions raised, then with only a disabled lane raised
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 47; k++) begin
        iss = '0;
        iss.valid = 1'b1;
        iss.op = fpx_pkg::fp_op_e'(k);
        iss.lane_en = j ? 2'h2 : 2'h3;
        iss.lane0_cond = 6'h3f;
        iss.lane1_cond = j ? 6'h00 : 6'h3f;
        iss.cmp_flags = 3'h5;
        cycle(iss, 1'b0, 16'h0000);
      end
    end
    $display("test allow table done");
    cycle('0, 1'b1, 16'h4000);
    rand_run(400, 1'b1);
    cycle('0, 1'b0, 16'h0000);
    $display("test random unmasked done");
    do_reset();
    rand_run(100, 1'b0);
    cycle('0, 1'b0, 16'h0000);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ### fpx_pkg.sv
// package: opcode classes, exception bit layout and control/status field positions
package fpx_pkg;
  // exception bit positions within a six-bit condition vector
  localparam int unsigned EX_INV  = 0;
  localparam int unsigned EX_DEN  = 1;
  localparam int unsigned EX_ZDIV = 2;
  localparam int unsigned EX_OVF  = 3;
  localparam int unsigned EX_UNF  = 4;
  localparam int unsigned EX_PREC = 5;
  localparam int unsigned EX_W    = 6;

  // control/status register layout: flags low, masks above, rounding mode above
  localparam int unsigned CSR_W       = 16;
  localparam int unsigned CSR_FLAG_LO = 0;
  localparam int unsigned CSR_MASK_LO = 7;
  localparam int unsigned CSR_RC_LO   = 13;
  localparam logic [15:0] CSR_RESET   = 16'h1f80;

  // condition sets
  localparam logic [5:0] SET_NONE  = 6'h00;
  localparam logic [5:0] SET_ARITH = 6'h3b; // i d o u p
  localparam logic [5:0] SET_ALL   = 6'h3f;
  localparam logic [5:0] SET_ID    = 6'h03;
  localparam logic [5:0] SET_IDP   = 6'h23;
  localparam logic [5:0] SET_P     = 6'h20;
  localparam logic [5:0] SET_IP    = 6'h21;

  // integer status flags from ordered/unordered compare
  localparam logic [2:0] CMP_UNORD = 3'h7; // zf pf cf
  localparam logic [2:0] CMP_GT    = 3'h0;
  localparam logic [2:0] CMP_LT    = 3'h1;
  localparam logic [2:0] CMP_EQ    = 3'h4;

  typedef enum logic [5:0] {
    add_packed_double, add_scalar_double, mul_packed_double, mul_scalar_double,
    sub_packed_double, sub_scalar_double, div_packed_double, div_scalar_double,
    cmp_predicate_packed, cmp_predicate_scalar, ordered_cmp_set_flags,
    unordered_cmp_set_flags, max_packed_double, max_scalar_double,
    min_packed_double, min_scalar_double, root_packed_double, root_scalar_double,
    bitwise_and_128, bitwise_andnot_128, bitwise_or_128, bitwise_xor_128,
    move_aligned_double, move_unaligned_double, move_high_double, move_low_double,
    move_scalar_double, extract_sign_bits, shuffle_double, interleave_high_double,
    interleave_low_double, int32x4_to_single, single_to_int32x4_round,
    single_to_int32x4_trunc, double_to_int32_round, double_to_int32_trunc,
    double_to_legacy_int32_round, double_to_legacy_int32_trunc,
    scalar_double_to_gpr_round, scalar_double_to_gpr_trunc, int32_to_double_packed,
    legacy_int32_to_double, gpr_int32_to_double, narrow_double_to_single,
    narrow_scalar_to_single, widen_single_to_double, widen_scalar_to_double
  } fp_op_e;

  // one issued instruction with the raw per-lane conditions from the datapath
  typedef struct packed {
    logic       valid;
    fp_op_e     op;
    logic [1:0] lane_en;
    logic [5:0] lane0_cond;
    logic [5:0] lane1_cond;
    logic [2:0] cmp_flags;
  } fp_issue_s;

  // result of one instruction
  typedef struct packed {
    logic       valid;
    logic [5:0] cond;
    logic       fault;
    logic       set_int_flags;
    logic [2:0] int_flags;
  } fp_result_s;
endpackage
